// *** verification/lcj_monitor.sv ***
// checker of the loop control and jump unit, bound to its top module
`timescale 1ns/1ps
module lcj_monitor (
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic I_CE,
  input wire lcj_pkg::lcj_req_t I_REQ,
  input wire lcj_pkg::lcj_res_t O_RES,
  input wire logic O_HIST_WE,
  input wire logic [35:0] O_HIST_TO,
  input wire logic I_FETCH_VALID,
  input wire logic [35:0] I_FETCH_PC,
  input wire logic I_FETCH_LOCAL,
  input wire logic O_FETCH_EXT_INT,
  input wire logic O_FETCH_PROT,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic O_AVS_WAITREQUEST
);
  import lcj_pkg::*;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);
  //--------------------
  // helper terms
  //--------------------
  // request taken, operand of a setup and a defined setup precision
  wire logic take = I_CE && I_REQ.valid && (I_REQ.op != LCJ_OP_NONE);
  wire logic [35:0] opnd = (I_REQ.op == LCJ_OP_SETUP_REG) ? I_REQ.greg : I_REQ.mem_op;
  wire logic setup = (I_REQ.op == LCJ_OP_SETUP_REG) || (I_REQ.op == LCJ_OP_SETUP_STOR);
  wire logic t_ok = (I_REQ.t == LCJ_T_SINGLE) || (I_REQ.t == LCJ_T_DOUBLE);
  sequence s_take; take; endsequence
  sequence s_answer; O_RES.done && (O_RES.ret == $past(I_REQ.pc) + 36'h1); endsequence
  sequence s_bus_req; (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST && I_CE; endsequence
  //--------------------
  // properties
  //--------------------
  property p_answer; s_take |=> s_answer; endproperty
  a_answer: assert property (p_answer) else $error("answer missing or wrong return address");
  property p_hist; O_HIST_WE |-> O_RES.done && O_RES.jump && (O_HIST_TO == O_RES.target); endproperty
  a_hist: assert property (p_hist) else $error("history entry without a taken jump");
  property p_local; s_take ##0 (I_REQ.op == LCJ_OP_JUMP_LOCAL) |=>
    O_RES.jump && (O_RES.target == {$past(I_REQ.pc[35:18]), 2'h0, $past(I_REQ.u)}); endproperty
  a_local: assert property (p_local) else $error("local jump target wrong");
  property p_far; s_take ##0 (I_REQ.op == LCJ_OP_JUMP_FAR) |=> O_RES.jump && (O_RES.target ==
    {$past(I_REQ.greg[35:18]), |$past(I_REQ.greg[17:16]), {1'b0, $past(I_REQ.greg[15:0])} + {1'b0, $past(I_REQ.u)}});
  endproperty
  a_far: assert property (p_far) else $error("far jump target wrong");
  property p_rlo; s_take ##0 (setup && t_ok && (opnd[35:30] != 6'h0)) |=> O_RES.int_rlo && !O_RES.jump; endproperty
  a_rlo: assert property (p_rlo) else $error("overflow interrupt missing on setup");
  property p_rsv_t; s_take ##0 (setup && !t_ok) |=> O_RES.reserved && !O_RES.jump; endproperty
  a_rsv_t: assert property (p_rsv_t) else $error("reserved precision not flagged");
  property p_inner; s_take ##0 (I_REQ.op == LCJ_OP_SHARED) && (I_REQ.sub == LCJ_SUB_ISETUP) |=>
    !O_RES.int_rlo && !O_RES.reserved; endproperty
  a_inner: assert property (p_inner) else $error("inner setup raised a fault");
  property p_ext; I_CE && I_FETCH_VALID |=> O_FETCH_EXT_INT == (|$past(I_FETCH_PC[17:16])); endproperty
  a_ext: assert property (p_ext) else $error("fetch address check wrong");
  property p_prot; I_CE && I_FETCH_VALID |=> O_FETCH_PROT == $past(I_FETCH_LOCAL); endproperty
  a_prot: assert property (p_prot) else $error("execute protection check wrong");
  property p_fetch_idle; !I_FETCH_VALID |=> !O_FETCH_EXT_INT && !O_FETCH_PROT; endproperty
  a_fetch_idle: assert property (p_fetch_idle) else $error("fetch fault without a fetch");
  property p_wait; s_bus_req |=> !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST; endproperty
  a_wait: assert property (p_wait) else $error("bus wait state count wrong");
endmodule
bind lcj_unit lcj_monitor u_mon (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_CE(I_CE), .I_REQ(I_REQ), .O_RES(O_RES),
  .O_HIST_WE(O_HIST_WE), .O_HIST_TO(O_HIST_TO), .I_FETCH_VALID(I_FETCH_VALID), .I_FETCH_PC(I_FETCH_PC),
  .I_FETCH_LOCAL(I_FETCH_LOCAL), .O_FETCH_EXT_INT(O_FETCH_EXT_INT), .O_FETCH_PROT(O_FETCH_PROT),
  .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST));

// *** verification/lcj_seq_model.sv ***
// sequencer model: fetches the instruction that follows each executed one
`timescale 1ns/1ps
module lcj_seq_model (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_slow,
  input wire lcj_pkg::lcj_res_t i_res,
  output logic o_fetch_valid,
  output logic [35:0] o_fetch_pc,
  output logic o_fetch_local
);
  import lcj_pkg::*;
  logic pend_q;
  logic [35:0] next_q;
  // next fetch is the jump target if taken, else the following word
  wire logic [35:0] next_pc = i_res.jump ? i_res.target : i_res.ret;
  wire logic now_fetch = i_res.done && !i_slow;
  // top three address bits all set mark the local storage segment here
  assign o_fetch_local = (o_fetch_pc[35:33] == 3'h7);
  // fetch at once or one cycle late; the address toggles while no fetch stands
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pend_q <= 1'b0;
      next_q <= '0;
      o_fetch_valid <= 1'b0;
      o_fetch_pc <= '0;
    end else begin
      pend_q <= i_res.done && i_slow;
      next_q <= next_pc;
      o_fetch_valid <= now_fetch || pend_q;
      o_fetch_pc <= pend_q ? next_q : (now_fetch ? next_pc : ~o_fetch_pc);
    end
  end
endmodule

// *** verification/loop_control_jump_unit_tb.sv ***
// self-checking bench of the loop control and jump unit
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin error_cnt++; $display("BAD %s exp %h got %h", n, e, s); end end
module loop_control_jump_unit_tb;
  import lcj_pkg::*;
  logic I_CLK, I_RST_B, I_CE, I_AVS_READ, I_AVS_WRITE, O_AVS_WAITREQUEST, O_HIST_WE, hist_en;
  logic I_FETCH_VALID, I_FETCH_LOCAL, O_FETCH_EXT_INT, O_FETCH_PROT, slow;
  logic [3:0] I_AVS_ADDRESS, I_AVS_BYTEENABLE;
  logic [31:0] I_AVS_WRITEDATA, O_AVS_READDATA, rd, seed;
  logic [35:0] I_FETCH_PC, O_HIST_FROM, O_HIST_TO, lt;
  lcj_req_t I_REQ, r;
  lcj_res_t O_RES, pend;
  int error_cnt, comparisons, sp, ip, hcnt, i;
  int rem[8], s1[8], s2[8], pos[8], lim[8];
  bit prec[8];
  lcj_unit DUT (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_CE(I_CE), .I_REQ(I_REQ), .O_RES(O_RES), .O_HIST_WE(O_HIST_WE),
    .O_HIST_FROM(O_HIST_FROM), .O_HIST_TO(O_HIST_TO), .I_FETCH_VALID(I_FETCH_VALID), .I_FETCH_PC(I_FETCH_PC),
    .I_FETCH_LOCAL(I_FETCH_LOCAL), .O_FETCH_EXT_INT(O_FETCH_EXT_INT), .O_FETCH_PROT(O_FETCH_PROT),
    .I_AVS_ADDRESS(I_AVS_ADDRESS), .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
    .I_AVS_WRITEDATA(I_AVS_WRITEDATA), .I_AVS_BYTEENABLE(I_AVS_BYTEENABLE), .O_AVS_READDATA(O_AVS_READDATA),
    .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST));
  lcj_seq_model u_seq (.i_clk(I_CLK), .i_rst_b(I_RST_B), .i_slow(slow), .i_res(O_RES),
    .o_fetch_valid(I_FETCH_VALID), .o_fetch_pc(I_FETCH_PC), .o_fetch_local(I_FETCH_LOCAL));
  //--------------------
  // helpers
  //--------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // strip count: remaining count capped at the full strip size
  function automatic int sc(int k);
    int full;
    full = prec[k] ? 32 : 64;
    return (rem[k] < full) ? rem[k] : full;
  endfunction
  task automatic stop_test();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // one bus cycle held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    @(posedge I_CLK);
    I_AVS_READ <= !wr;
    I_AVS_WRITE <= wr;
    I_AVS_ADDRESS <= a;
    I_AVS_WRITEDATA <= d;
    I_AVS_BYTEENABLE <= be;
    for (n = 0; n < 50; n++) begin
      @(posedge I_CLK);
      if (O_AVS_WAITREQUEST === 1'b0) break;
    end
    if (n == 50) begin
      `CHK("bus wait", 1'b0, 1'b1)
      stop_test();
    end
    rd = O_AVS_READDATA;
    I_AVS_READ <= 1'b0;
    I_AVS_WRITE <= 1'b0;
  endtask
  // reference behaviour of one instruction
  task automatic model(input lcj_req_t q, output lcj_res_t x);
    logic [35:0] opnd;
    int v;
    x = '0;
    x.done = 1'b1;
    x.ret = q.pc + 36'h1;
    x.target = {q.pc[35:18], 2'h0, q.u};
    opnd = (q.op == LCJ_OP_SETUP_REG) ? q.greg : q.mem_op;
    case (q.op)
      LCJ_OP_SETUP_STOR, LCJ_OP_SETUP_REG: begin
        if (q.t != LCJ_T_SINGLE && q.t != LCJ_T_DOUBLE) x.reserved = 1'b1;
        else if (opnd[35:30] != 6'h0) x.int_rlo = 1'b1;
        else begin
          v = sc(sp);
          s2[q.e] = s1[sp];
          s1[q.e] = v;
          rem[q.e] = opnd[29:0];
          prec[q.e] = (q.t == LCJ_T_DOUBLE);
          sp = q.e;
        end
      end
      LCJ_OP_SHARED: begin
        case (q.sub)
          LCJ_SUB_SCLOSE: begin
            v = rem[sp] - sc(sp);
            x.jump = v > 0;
            rem[sp] = x.jump ? v : 0;
            if (!x.jump) sp = q.e;
          end
          LCJ_SUB_ISETUP: begin
            ip = q.e;
            pos[ip] = 0;
            lim[ip] = (q.l == 0) ? sc(sp) : (q.l == 1) ? s1[sp] : (q.l == 2) ? s2[sp] : rem[sp];
            x.jump = lim[ip] == 0;
          end
          LCJ_SUB_ICLOSE: begin
            x.jump = pos[ip] + 1 < lim[ip];
            if (x.jump) pos[ip]++;
            else ip = q.e;
          end
          default: x.reserved = 1'b1;
        endcase
      end
      LCJ_OP_PTR_ADJ: begin
        if (q.p[0]) ip = q.e;
        if (q.p[1]) sp = q.e;
      end
      LCJ_OP_JUMP_LOCAL: x.jump = 1'b1;
      LCJ_OP_JUMP_FAR: begin
        x.jump = 1'b1;
        x.target = {q.greg[35:18], |q.greg[17:16], {1'b0, q.greg[15:0]} + {1'b0, q.u}};
      end
      default: x.done = 1'b0;
    endcase
    if (x.jump && hist_en) begin
      hcnt++;
      lt = x.target;
    end
  endtask
  // present the next request and check the answer to the previous one
  task automatic step(input lcj_req_t q);
    @(posedge I_CLK);
    I_REQ <= q;
    #1;
    `CHK("done", pend.done, O_RES.done)
    if (pend.done) begin
      `CHK("jump", pend.jump, O_RES.jump)
      `CHK("int", pend.int_rlo, O_RES.int_rlo)
      `CHK("reserved", pend.reserved, O_RES.reserved)
      `CHK("ret", pend.ret, O_RES.ret)
      `CHK("hist", pend.jump && hist_en, O_HIST_WE)
      if (pend.jump) begin
        `CHK("target", pend.target, O_RES.target)
        `CHK("hist from", pend.ret - 36'h1, O_HIST_FROM)
        `CHK("hist to", pend.target, O_HIST_TO)
      end
    end
    pend = '0;
    if (q.valid) model(q, pend);
  endtask
  //--------------------
  // clock and main sequence
  //--------------------
  initial begin
    I_CLK = 1'b0;
    forever #4 I_CLK = ~I_CLK;
  end
  initial begin
    {I_RST_B, I_AVS_READ, I_AVS_WRITE, slow, error_cnt, comparisons, sp, ip, hcnt} = '0;
    {I_REQ, pend, I_AVS_ADDRESS, I_AVS_WRITEDATA, I_AVS_BYTEENABLE, lt} = '0;
    I_CE = 1'b1;
    hist_en = 1'b1;
    seed = 32'ha23a;
    repeat (3) @(posedge I_CLK);
    I_RST_B <= 1'b1;
    // reset values, a write to a read-only place and a read of an unmapped place
    bus(1'b0, LCJ_REG_CTRL, 32'h0, 4'hf);
    `CHK("ctrl", LCJ_CTRL_RST, rd)
    bus(1'b1, LCJ_REG_STATUS, 32'hffff_ffff, 4'hf);
    bus(1'b0, LCJ_REG_STATUS, 32'h0, 4'hf);
    `CHK("status", 32'h0, rd)
    bus(1'b0, 4'h2, 32'h0, 4'hf);
    `CHK("unmapped", 32'h0, rd)
    // random back-to-back instruction stream with register checks between
    for (i = 0; i < 800; i++) begin
      r = '0;
      r.valid = 1'b1;
      r.op = rnd() % 2 ? LCJ_OP_SHARED : lcj_op_t'(1 + rnd() % 6);
      r.sub = (rnd() % 5 == 0) ? 3'(rnd()) : 3'(1 + rnd() % 3);
      r.t = (rnd() % 5 == 0) ? 3'(rnd()) : 3'(5 + rnd() % 2);
      {r.e, r.p, r.l, r.u} = 23'(rnd());
      r.pc = {4'(rnd()), rnd()};
      r.mem_op = {6'h0, 30'(rnd() % 300)};
      if ((r.t == LCJ_T_SINGLE || r.t == LCJ_T_DOUBLE) && rnd() % 12 == 0) r.mem_op[35:30] = 6'h21;
      r.greg = (r.op == LCJ_OP_SETUP_REG) ? r.mem_op : {4'(rnd()), rnd()};
      if (r.op == LCJ_OP_SETUP_REG) r.mem_op = ~r.mem_op;
      step(r);
      if (rnd() % 8 == 0) step('0);
      slow <= (i > 400);
      if (i % 50 == 49 || i == 150 || i == 300 || i == 500) step('0);
      if (i % 50 == 49) begin
        bus(1'b0, LCJ_REG_STATUS, 32'h0, 4'hf);
        `CHK("pointers", 32'(ip * 16 + sp), rd & 32'h77)
      end
      if (i == 150) begin
        bus(1'b0, LCJ_REG_HCOUNT, 32'h0, 4'hf);
        `CHK("hcount", 32'(hcnt), rd)
        bus(1'b0, LCJ_REG_TARGET, 32'h0, 4'hf);
        `CHK("target reg", lt[31:0], rd)
        bus(1'b1, LCJ_REG_HCOUNT, 32'h0, 4'hf);
        bus(1'b0, LCJ_REG_HCOUNT, 32'h0, 4'hf);
        `CHK("hcount clear", 32'h0, rd)
        bus(1'b1, LCJ_REG_CTRL, 32'h0, 4'h0);
        bus(1'b0, LCJ_REG_CTRL, 32'h0, 4'hf);
        `CHK("ctrl byte enable", LCJ_CTRL_RST, rd)
      end
      if (i == 300 || i == 500) begin
        hist_en = (i == 500);
        bus(1'b1, LCJ_REG_CTRL, 32'(hist_en), 4'hf);
      end
    end
    step('0);
    step('0);
    stop_test();
  end
endmodule

// *** verilog/lcj_pkg.sv ***
// package of constants and types for the loop control and jump unit
//------------------------------------------------------------------------
// Summary of operation
// - strip-loop setup takes element count from operand bits 6-35.
// - nonzero operand bits 0-5 on strip-loop setup raise interrupt type 13.
// - setup operand from storage (base+offset) or from second general register.
// - setup writes entry chosen by e-field, then strip-loop pointer points there.
// - new entry: precision from t, remaining=operand, saved counts shift down.
// - setup defined only for t of 5 and 6, giving precision 0 and 1.
// - close subtracts strip count from remaining; positive jumps, else pointer from e.
// - close, inner setup, inner close share opcode; bits 7-9 are 001, 010, 011.
// - inner setup points pointer at e entry, clears position, loads limit from l.
// - inner setup length comes from current strip-loop entry.
// - after loading limit, jump when it is zero, else continue.
// - inner count limit above 64 raises no fault.
// - inner close adds one; below limit stores and jumps, else pointer from e.
// - pointer adjust loads pointers from e per p-field; loop contents unchanged.
// - fetch with program counter bit 18 or 19 set raises external interrupt.
// - executing code in local storage segment raises execute protection check.
// - local target is counter bits 0-17, zeros, then 16-bit u-field.
// - far target: register high bits, OR bit, carry, and unsigned low sum.
// - every taken jump appends an entry to the jump history file; the code appends only while ctrl bit LCJ_CTRL_HIST_EN is set.
// - jump raising synchronous interrupt is not taken; return is next instruction.
// - target address faults are reported at next fetch, not at the jump.
//------------------------------------------------------------------------
package lcj_pkg;

  //----------------------------------------------------------------------
  // word layout (bit 0 of the word is the msb)
  //----------------------------------------------------------------------
  localparam int LCJ_WORD_W = 36;
  localparam int LCJ_CNT_W = 30;
  localparam int LCJ_PTR_W = 3;
  localparam int LCJ_NENT = 8;
  localparam int LCJ_U_W = 16;
  localparam int LCJ_SEG_HI = 18; // width of counter bits 0-17

  // instruction field codes
  localparam logic [2:0] LCJ_T_SINGLE = 3'h5;
  localparam logic [2:0] LCJ_T_DOUBLE = 3'h6;
  localparam logic [2:0] LCJ_SUB_SCLOSE = 3'h1;
  localparam logic [2:0] LCJ_SUB_ISETUP = 3'h2;
  localparam logic [2:0] LCJ_SUB_ICLOSE = 3'h3;
  localparam logic [1:0] LCJ_P_INNER = 2'h1;
  localparam logic [1:0] LCJ_P_STRIP = 2'h2;
  localparam logic [1:0] LCJ_P_BOTH = 2'h3;
  localparam logic [1:0] LCJ_L_STRIP = 2'h0;
  localparam logic [1:0] LCJ_L_SAVED1 = 2'h1;
  localparam logic [1:0] LCJ_L_SAVED2 = 2'h2;

  // full strip sizes per precision
  localparam logic [29:0] LCJ_FULL_SINGLE = 30'h40;
  localparam logic [29:0] LCJ_FULL_DOUBLE = 30'h20;
  localparam logic [7:0] LCJ_INT_TYPE_RLO = 8'h0d;

  //----------------------------------------------------------------------
  // register map (byte offsets) and reset values
  //----------------------------------------------------------------------
  localparam logic [3:0] LCJ_REG_CTRL = 4'h0;
  localparam logic [3:0] LCJ_REG_STATUS = 4'h4;
  localparam logic [3:0] LCJ_REG_HCOUNT = 4'h8;
  localparam logic [3:0] LCJ_REG_TARGET = 4'hc;
  localparam int LCJ_CTRL_HIST_EN = 0;
  localparam logic [31:0] LCJ_CTRL_RST = 32'h0000_0001;

  //----------------------------------------------------------------------
  // types
  //----------------------------------------------------------------------
  typedef enum logic [2:0] {
    LCJ_OP_NONE,
    LCJ_OP_SETUP_STOR,
    LCJ_OP_SETUP_REG,
    LCJ_OP_SHARED,
    LCJ_OP_PTR_ADJ,
    LCJ_OP_JUMP_LOCAL,
    LCJ_OP_JUMP_FAR
  } lcj_op_t;

  typedef struct packed {
    logic valid;
    lcj_op_t op;
    logic [2:0] sub;
    logic [2:0] t;
    logic [2:0] e;
    logic [1:0] p;
    logic [1:0] l;
    logic [15:0] u;
    logic [35:0] mem_op;
    logic [35:0] greg;
    logic [35:0] pc;
  } lcj_req_t;

  typedef struct packed {
    logic done;
    logic jump;
    logic int_rlo;
    logic reserved;
    logic [35:0] target;
    logic [35:0] ret;
  } lcj_res_t;

  typedef struct packed {
    logic precision_flag;
    logic [29:0] remaining_count;
    logic [29:0] saved_count_one;
    logic [29:0] saved_count_two;
  } lcj_strip_t;

  typedef struct packed {
    logic [29:0] inner_position;
    logic [29:0] inner_count_limit;
  } lcj_inner_t;

endpackage

// *** verilog/lcj_unit.sv ***
// loop control and jump execution unit with avalon-mm status registers
`timescale 1ns/1ps
module lcj_unit (
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic I_CE,
  // instruction from decoder
  input wire lcj_pkg::lcj_req_t I_REQ,
  output lcj_pkg::lcj_res_t O_RES,
  // jump history append port
  output logic O_HIST_WE,
  output logic [35:0] O_HIST_FROM,
  output logic [35:0] O_HIST_TO,
  // fetch check
  input wire logic I_FETCH_VALID,
  input wire logic [35:0] I_FETCH_PC,
  input wire logic I_FETCH_LOCAL,
  output logic O_FETCH_EXT_INT,
  output logic O_FETCH_PROT,
  // avalon-mm slave
  input wire logic [3:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST
);
  import lcj_pkg::*;

  //--------------------
  // state
  //--------------------
  lcj_strip_t sl_q [LCJ_NENT];
  lcj_inner_t il_q [LCJ_NENT];
  logic [2:0] slp_q, slp_d;
  logic [2:0] ilp_q, ilp_d;
  lcj_res_t res_q, res_d;
  logic hist_we_q;
  logic [35:0] hist_from_q, hist_to_q;
  logic fetch_ext_q, fetch_prot_q;
  logic [31:0] ctrl_q;
  logic [31:0] hcount_q;
  logic [35:0] last_tgt_q;
  logic wait_q;
  logic [31:0] rdata_q;

  // current entries as the instruction finds them
  lcj_strip_t sl_cur;
  lcj_inner_t il_cur;
  assign sl_cur = sl_q[slp_q];
  assign il_cur = il_q[ilp_q];

  // strip count of an entry: remaining elements capped at the full strip
  function automatic logic [29:0] strip_count(input lcj_strip_t s);
    logic [29:0] full;
    full = s.precision_flag ? LCJ_FULL_DOUBLE : LCJ_FULL_SINGLE;
    strip_count = (s.remaining_count > full) ? full : s.remaining_count;
  endfunction

  //--------------------
  // instruction decode
  //--------------------
  wire ex = I_CE && I_REQ.valid;
  wire is_setup = (I_REQ.op == LCJ_OP_SETUP_STOR) || (I_REQ.op == LCJ_OP_SETUP_REG);
  wire is_shared = (I_REQ.op == LCJ_OP_SHARED);
  wire is_sclose = is_shared && (I_REQ.sub == LCJ_SUB_SCLOSE);
  wire is_isetup = is_shared && (I_REQ.sub == LCJ_SUB_ISETUP);
  wire is_iclose = is_shared && (I_REQ.sub == LCJ_SUB_ICLOSE);
  wire is_padj = (I_REQ.op == LCJ_OP_PTR_ADJ);
  wire is_jlocal = (I_REQ.op == LCJ_OP_JUMP_LOCAL);
  wire is_jfar = (I_REQ.op == LCJ_OP_JUMP_FAR);
  wire shared_bad = is_shared && !is_sclose && !is_isetup && !is_iclose;

  //--------------------
  // strip-loop setup
  //--------------------
  // operand from storage or from the second general register
  wire [35:0] setup_opnd = (I_REQ.op == LCJ_OP_SETUP_STOR) ? I_REQ.mem_op : I_REQ.greg;
  wire setup_rlo = is_setup && (setup_opnd[35:30] != 6'h00);
  wire t_ok = (I_REQ.t == LCJ_T_SINGLE) || (I_REQ.t == LCJ_T_DOUBLE);
  wire setup_res = is_setup && !t_ok;
  wire setup_go = ex && is_setup && t_ok && !setup_rlo;

  // new entry built from the entry selected before this instruction
  lcj_strip_t sl_new;
  assign sl_new.precision_flag = (I_REQ.t == LCJ_T_DOUBLE);
  assign sl_new.remaining_count = setup_opnd[29:0];
  assign sl_new.saved_count_one = strip_count(sl_cur);
  assign sl_new.saved_count_two = sl_cur.saved_count_one;

  //--------------------
  // strip-loop close
  //--------------------
  wire [29:0] cur_strip = strip_count(sl_cur);
  wire [30:0] sc_diff = {1'b0, sl_cur.remaining_count} - {1'b0, cur_strip};
  wire sc_pos = !sc_diff[30] && (sc_diff[29:0] != 30'h0);
  lcj_strip_t sl_closed;
  assign sl_closed.precision_flag = sl_cur.precision_flag;
  assign sl_closed.remaining_count = sc_diff[30] ? 30'h0 : sc_diff[29:0];
  assign sl_closed.saved_count_one = sl_cur.saved_count_one;
  assign sl_closed.saved_count_two = sl_cur.saved_count_two;

  //--------------------
  // inner-loop setup and close
  //--------------------
  // length parameter drawn from the current strip-loop entry
  wire [29:0] len_sel = (I_REQ.l == LCJ_L_STRIP) ? cur_strip :
                        (I_REQ.l == LCJ_L_SAVED1) ? sl_cur.saved_count_one :
                        (I_REQ.l == LCJ_L_SAVED2) ? sl_cur.saved_count_two :
                        sl_cur.remaining_count;
  lcj_inner_t il_new;
  assign il_new.inner_position = 30'h0;
  assign il_new.inner_count_limit = len_sel;
  wire is_zero_lim = (len_sel == 30'h0);

  wire [30:0] ic_sum = {1'b0, il_cur.inner_position} + 31'h1;
  wire ic_below = ic_sum < {1'b0, il_cur.inner_count_limit};
  lcj_inner_t il_stepped;
  assign il_stepped.inner_position = ic_sum[29:0];
  assign il_stepped.inner_count_limit = il_cur.inner_count_limit;

  //--------------------
  // jump target formation
  //--------------------
  wire [35:0] tgt_local = {I_REQ.pc[35:18], 2'b00, I_REQ.u};
  wire [16:0] far_sum = {1'b0, I_REQ.u} + {1'b0, I_REQ.greg[15:0]};
  wire [35:0] tgt_far = {I_REQ.greg[35:18], I_REQ.greg[17] | I_REQ.greg[16], far_sum};
  // no target check here: faults on the target show up at its fetch
  wire [35:0] tgt = is_jfar ? tgt_far : tgt_local;
  wire [35:0] ret_addr = I_REQ.pc + 36'h1;

  //--------------------
  // jump condition and interrupt suppression
  //--------------------
  wire sync_int = setup_rlo; // only synchronous interrupt this unit raises
  wire jcond = (is_sclose && sc_pos) || (is_isetup && is_zero_lim) ||
               (is_iclose && ic_below) || is_jlocal || is_jfar;
  wire jtake = ex && jcond && !sync_int;

  //--------------------
  // loop register writes, one generate entry per register
  //--------------------
  wire sl_we_any = setup_go || (ex && is_sclose);
  wire [2:0] sl_widx = is_setup ? I_REQ.e : slp_q;
  lcj_strip_t sl_wdata;
  assign sl_wdata = is_setup ? sl_new : sl_closed;

  wire il_we_any = (ex && is_isetup) || (ex && is_iclose && ic_below);
  wire [2:0] il_widx = is_isetup ? I_REQ.e : ilp_q;
  lcj_inner_t il_wdata;
  assign il_wdata = is_isetup ? il_new : il_stepped;

  genvar gi;
  generate
    for (gi = 0; gi < LCJ_NENT; gi = gi + 1) begin : g_ent
      // strip and inner loop entry storage
      always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
          sl_q[gi] <= '0;
          il_q[gi] <= '0;
        end else begin
          if (sl_we_any && (sl_widx == 3'(gi))) begin
            sl_q[gi] <= sl_wdata;
          end
          if (il_we_any && (il_widx == 3'(gi))) begin
            il_q[gi] <= il_wdata;
          end
        end
      end
    end
  endgenerate

  //--------------------
  // pointer updates
  //--------------------
  wire padj_strip = is_padj && ((I_REQ.p == LCJ_P_STRIP) || (I_REQ.p == LCJ_P_BOTH));
  wire padj_inner = is_padj && ((I_REQ.p == LCJ_P_INNER) || (I_REQ.p == LCJ_P_BOTH));
  wire slp_load = setup_go || (ex && is_sclose && !sc_pos) || (ex && padj_strip);
  wire ilp_load = (ex && is_isetup) || (ex && is_iclose && !ic_below) || (ex && padj_inner);
  assign slp_d = slp_load ? I_REQ.e : slp_q;
  assign ilp_d = ilp_load ? I_REQ.e : ilp_q;

  // pointer registers
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      slp_q <= 3'h0;
      ilp_q <= 3'h0;
    end else if (I_CE) begin
      slp_q <= slp_d;
      ilp_q <= ilp_d;
    end
  end

  //--------------------
  // result to sequencer
  //--------------------
  assign res_d.done = ex && (I_REQ.op != LCJ_OP_NONE);
  assign res_d.jump = jtake;
  assign res_d.int_rlo = ex && setup_rlo;
  assign res_d.reserved = ex && (setup_res || shared_bad);
  assign res_d.target = tgt;
  assign res_d.ret = ret_addr;

  // result and history registers
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      res_q <= '0;
      hist_we_q <= 1'b0;
      hist_from_q <= 36'h0;
      hist_to_q <= 36'h0;
    end else if (I_CE) begin
      res_q <= res_d;
      hist_we_q <= jtake && ctrl_q[LCJ_CTRL_HIST_EN];
      hist_from_q <= I_REQ.pc;
      hist_to_q <= tgt;
    end else begin
      res_q.done <= 1'b0;
      hist_we_q <= 1'b0;
    end
  end

  //--------------------
  // fetch address check
  //--------------------
  wire fetch_go = I_CE && I_FETCH_VALID;
  wire fetch_bad_pc = fetch_go && (I_FETCH_PC[17:16] != 2'b00);
  wire fetch_local = fetch_go && I_FETCH_LOCAL;

  // fetch check pulses
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      fetch_ext_q <= 1'b0;
      fetch_prot_q <= 1'b0;
    end else begin
      fetch_ext_q <= fetch_bad_pc;
      fetch_prot_q <= fetch_local;
    end
  end

  //--------------------
  // avalon-mm slave: one wait state, then answer
  //--------------------
  wire bus_req = I_AVS_READ || I_AVS_WRITE;
  wire bus_fire = bus_req && !wait_q; // edge where waitrequest is sampled low
  wire wr_ctrl = bus_fire && I_AVS_WRITE && (I_AVS_ADDRESS == LCJ_REG_CTRL);
  wire wr_hcnt = bus_fire && I_AVS_WRITE && (I_AVS_ADDRESS == LCJ_REG_HCOUNT);
  wire [31:0] be_mask = {{8{I_AVS_BYTEENABLE[3]}}, {8{I_AVS_BYTEENABLE[2]}},
                         {8{I_AVS_BYTEENABLE[1]}}, {8{I_AVS_BYTEENABLE[0]}}};
  wire [31:0] status_v = {22'h0, res_q.int_rlo, res_q.jump, 1'b0,
                          ilp_q, 1'b0, slp_q};
  wire [31:0] rd_mux = (I_AVS_ADDRESS == LCJ_REG_CTRL) ? ctrl_q :
                       (I_AVS_ADDRESS == LCJ_REG_STATUS) ? status_v :
                       (I_AVS_ADDRESS == LCJ_REG_HCOUNT) ? hcount_q :
                       (I_AVS_ADDRESS == LCJ_REG_TARGET) ? last_tgt_q[31:0] :
                       32'h0;
  wire hist_inc = I_CE && jtake && ctrl_q[LCJ_CTRL_HIST_EN];

  // bus handshake and read data
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end else if (I_CE) begin
      wait_q <= !(bus_req && wait_q);
      if (I_AVS_READ && wait_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // control register, history counter and last target
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ctrl_q <= LCJ_CTRL_RST;
      hcount_q <= 32'h0;
      last_tgt_q <= 36'h0;
    end else if (I_CE) begin
      if (wr_ctrl) begin
        ctrl_q <= (ctrl_q & ~be_mask) | (I_AVS_WRITEDATA & be_mask & 32'h1);
      end
      if (hist_inc) begin
        hcount_q <= hcount_q + 32'h1; // counting wins over a clear
        last_tgt_q <= tgt;
      end else if (wr_hcnt) begin
        hcount_q <= 32'h0;
      end
    end
  end

  //--------------------
  // outputs
  //--------------------
  assign O_RES = res_q;
  assign O_HIST_WE = hist_we_q;
  assign O_HIST_FROM = hist_from_q;
  assign O_HIST_TO = hist_to_q;
  assign O_FETCH_EXT_INT = fetch_ext_q;
  assign O_FETCH_PROT = fetch_prot_q;
  assign O_AVS_READDATA = rdata_q;
  assign O_AVS_WAITREQUEST = wait_q;

endmodule
